//--- spr_pkg.sv
package spr_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NUM_CH = 2;
    localparam int NUM_EV = 4;
    localparam int NUM_PINS = 5;

    typedef logic [ADDR_W-1:0] spr_addr_t;
    typedef logic [DATA_W-1:0] spr_word_t;
    typedef logic [NUM_EV-1:0] spr_ev_t;
    typedef logic [7:0]        spr_ctl_t;
    typedef logic [NUM_PINS-1:0] spr_pins_t;

    // byte addresses of the register words
    localparam spr_addr_t OFS_STATUS = 8'h00;
    localparam spr_addr_t OFS_MASK   = 8'h04;
    localparam spr_addr_t OFS_CTRL   = 8'h08;
    localparam spr_addr_t OFS_PINS   = 8'h0C;
    localparam spr_addr_t OFS_PEND   = 8'h10;

    // status and mask layout: two bits per channel
    localparam int EV_PER_CH  = 2;
    localparam int EV_RDY_OFS = 0;
    localparam int EV_ERR_OFS = 1;

    // indicator control layout
    localparam int CTL_SEL_BASE = 0;
    localparam int CTL_IND_BASE = 4;
    localparam int CTL_W        = 8;

    // pin index order inside the pin vector
    localparam int PIN_IRQ   = 0;
    localparam int PIN_A_RDY = 1;
    localparam int PIN_A_ERR = 2;
    localparam int PIN_B_RDY = 3;
    localparam int PIN_B_ERR = 4;
    localparam int PIN_CH_BASE = 1;

    localparam spr_ev_t   STATUS_RST = 4'h0;
    localparam spr_ev_t   MASK_RST   = 4'h0;
    localparam spr_ctl_t  CTRL_RST   = 8'h00;
    localparam spr_word_t WORD_ZERO  = 32'h00000000;

    // open-drain drive level while asserted
    localparam logic PIN_ACTIVE_LVL = 1'b0;

endpackage

//--- spr_sync2.sv
`timescale 1ns/1ns
module spr_sync2
    import spr_pkg::*;
(
    // clock and reset
    input  wire logic            clk,
    input  wire logic            sys_rst,
    // levels from outside the clock domain
    input  wire spr_pkg::spr_pins_t async_in,
    // synchronised levels
    output spr_pkg::spr_pins_t      sync_out
);
    import spr_pkg::*;

    spr_pins_t stage1_ff;
    spr_pins_t stage2_ff;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stage1_ff <= '1;
            stage2_ff <= '1;
        end else begin
            stage1_ff <= async_in;
            stage2_ff <= stage1_ff;
        end
    end

    assign sync_out = stage2_ff;

endmodule

//--- spr_od_pin.sv
`timescale 1ns/1ns
module spr_od_pin
    import spr_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // request to pull the pin low
    input  wire logic assert_req,
    // open-drain pin drive
    output logic      pin_out,
    output logic      pin_oe
);
    import spr_pkg::*;

    logic out_ff;
    logic oe_ff;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            out_ff <= PIN_ACTIVE_LVL;
            oe_ff  <= 1'b0;
        end else begin
            out_ff <= PIN_ACTIVE_LVL;
            oe_ff  <= assert_req;
        end
    end

    assign pin_out = out_ff;
    assign pin_oe  = oe_ff;

endmodule

//--- spr_status_pin_router.sv
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ns
module spr_status_pin_router
    import spr_pkg::*;
(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               sys_rst,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire spr_pkg::spr_addr_t paddr,
    input  wire spr_pkg::spr_word_t pwdata,
    output spr_pkg::spr_word_t      prdata,
    output logic                    pready,
    output logic                    pslverr,
    // event pulses from the channel receivers
    input  wire logic               chan_a_rx_avail_flag,
    input  wire logic               chan_a_rx_fault_flag,
    input  wire logic               chan_b_rx_avail_flag,
    input  wire logic               chan_b_rx_fault_flag,
    // level interrupt, active high
    output logic                    irq_o,
    // shared open-drain interrupt pin, active low
    input  wire logic               irq_pin_in,
    output logic                    irq_pin_out,
    output logic                    irq_pin_oe,
    // channel A open-drain pins
    input  wire logic               chan_a_ready_pin_in,
    output logic                    chan_a_ready_pin_out,
    output logic                    chan_a_ready_pin_oe,
    input  wire logic               chan_a_error_pin_in,
    output logic                    chan_a_error_pin_out,
    output logic                    chan_a_error_pin_oe,
    // channel B open-drain pins
    input  wire logic               chan_b_ready_pin_in,
    output logic                    chan_b_ready_pin_out,
    output logic                    chan_b_ready_pin_oe,
    input  wire logic               chan_b_error_pin_in,
    output logic                    chan_b_error_pin_out,
    output logic                    chan_b_error_pin_oe
);
    import spr_pkg::*;

    // decode helpers, shared by read mux, error answer and write strobes
    function automatic logic reg_hit(input spr_addr_t addr, input spr_addr_t ofs);
        reg_hit = (addr == ofs);
    endfunction

    function automatic logic addr_mapped(input spr_addr_t addr);
        addr_mapped = reg_hit(addr, OFS_STATUS) || reg_hit(addr, OFS_MASK)
                   || reg_hit(addr, OFS_CTRL) || reg_hit(addr, OFS_PINS)
                   || reg_hit(addr, OFS_PEND);
    endfunction

    // registers
    spr_ev_t   event_status_ff;
    spr_ev_t   nxt_event_status;
    spr_ev_t   event_mask_reg_ff;
    spr_ctl_t  indicator_control_reg_ff;
    spr_word_t prdata_ff;
    spr_word_t nxt_prdata;
    logic      pready_ff;
    logic      pslverr_ff;
    logic      irq_ff;
    spr_ev_t   rd_clear_ff;

    // bus phase decode
    logic      setup_phase;
    logic      access_done;
    logic      wr_done;
    logic      rd_status_done;

    // event vector and pin routing
    spr_ev_t   event_in;
    spr_ev_t   pending;
    spr_pins_t pin_assert;
    spr_pins_t pin_raw;
    spr_pins_t pin_level;
    spr_pins_t pin_out_w;
    spr_pins_t pin_oe_w;

    // per-channel views of the control bits
    logic [NUM_CH-1:0] rdy_irq_sel;
    logic [NUM_CH-1:0] err_irq_sel;
    logic [NUM_CH-1:0] ind1_on;
    logic [NUM_CH-1:0] ind2_on;

    assign event_in[EV_RDY_OFS]             = chan_a_rx_avail_flag;
    assign event_in[EV_ERR_OFS]             = chan_a_rx_fault_flag;
    assign event_in[EV_PER_CH + EV_RDY_OFS] = chan_b_rx_avail_flag;
    assign event_in[EV_PER_CH + EV_ERR_OFS] = chan_b_rx_fault_flag;

    // bus phases
    assign setup_phase    = psel && !penable;
    assign access_done    = psel && penable && pready_ff;
    assign wr_done        = access_done && pwrite && !pslverr_ff;
    assign rd_status_done = access_done && !pwrite && reg_hit(paddr, OFS_STATUS);

    // answer is prepared in the setup cycle so pready can come from a flop
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pready_ff <= 1'b0;
        end else begin
            pready_ff <= setup_phase;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pslverr_ff <= 1'b0;
        end else if (setup_phase) begin
            pslverr_ff <= !addr_mapped(paddr);
        end else if (access_done) begin
            pslverr_ff <= 1'b0;
        end
    end

    // read mux
    always_comb begin
        nxt_prdata = WORD_ZERO;
        if (reg_hit(paddr, OFS_STATUS)) begin
            nxt_prdata[NUM_EV-1:0] = event_status_ff;
        end else if (reg_hit(paddr, OFS_MASK)) begin
            nxt_prdata[NUM_EV-1:0] = event_mask_reg_ff;
        end else if (reg_hit(paddr, OFS_CTRL)) begin
            nxt_prdata[CTL_W-1:0] = indicator_control_reg_ff;
        end else if (reg_hit(paddr, OFS_PINS)) begin
            nxt_prdata[NUM_PINS-1:0] = pin_level;
        end else if (reg_hit(paddr, OFS_PEND)) begin
            nxt_prdata[NUM_EV-1:0] = pending;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata_ff <= WORD_ZERO;
        end else if (setup_phase && !pwrite) begin
            prdata_ff <= nxt_prdata;
        end else if (access_done) begin
            prdata_ff <= WORD_ZERO;
        end
    end

    // only the bits actually returned are cleared, so a flag raised
    // between the setup and access edges survives the read
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_clear_ff <= STATUS_RST;
        end else if (setup_phase && !pwrite && reg_hit(paddr, OFS_STATUS)) begin
            rd_clear_ff <= event_status_ff;
        end else if (access_done) begin
            rd_clear_ff <= STATUS_RST;
        end
    end

    // sticky status: a new event wins over the read clear
    always_comb begin
        nxt_event_status = event_status_ff;
        if (rd_status_done) begin
            nxt_event_status = nxt_event_status & ~rd_clear_ff;
        end
        nxt_event_status = nxt_event_status | event_in;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            event_status_ff <= STATUS_RST;
        end else begin
            event_status_ff <= nxt_event_status;
        end
    end

    // mask register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            event_mask_reg_ff <= MASK_RST;
        end else if (wr_done && reg_hit(paddr, OFS_MASK)) begin
            event_mask_reg_ff <= pwdata[NUM_EV-1:0];
        end
    end

    // pin mode and indicator control
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            indicator_control_reg_ff <= CTRL_RST;
        end else if (wr_done && reg_hit(paddr, OFS_CTRL)) begin
            indicator_control_reg_ff <= pwdata[CTL_W-1:0];
        end
    end

    assign pending = event_status_ff & event_mask_reg_ff;

    // level interrupt register
    // taken from the registered status so the level and the shared pin
    // move on the same edge, one edge after the status bit
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |pending;
        end
    end

    assign pin_assert[PIN_IRQ] = |pending;

    // per-channel routing; channel 0 is A, channel 1 is B
    generate
        for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
            assign rdy_irq_sel[c] = indicator_control_reg_ff[CTL_SEL_BASE + EV_PER_CH*c];
            assign err_irq_sel[c] = indicator_control_reg_ff[CTL_SEL_BASE + EV_PER_CH*c + 1];
            assign ind1_on[c]     = indicator_control_reg_ff[CTL_IND_BASE + EV_PER_CH*c];
            assign ind2_on[c]     = indicator_control_reg_ff[CTL_IND_BASE + EV_PER_CH*c + 1];

            assign pin_assert[PIN_CH_BASE + EV_PER_CH*c + EV_RDY_OFS] =
                rdy_irq_sel[c] ? event_status_ff[EV_PER_CH*c + EV_RDY_OFS]
                               : ind1_on[c];

            assign pin_assert[PIN_CH_BASE + EV_PER_CH*c + EV_ERR_OFS] =
                err_irq_sel[c] ? event_status_ff[EV_PER_CH*c + EV_ERR_OFS]
                               : ind2_on[c];
        end
    endgenerate

    generate
        for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
            spr_od_pin u_pin (
                .clk        (clk),
                .sys_rst    (sys_rst),
                .assert_req (pin_assert[p]),
                .pin_out    (pin_out_w[p]),
                .pin_oe     (pin_oe_w[p])
            );
        end
    endgenerate

    // pin levels come back from the board wire, so they are synchronised
    // before software may read them; a pin held low externally shows here
    assign pin_raw[PIN_IRQ]   = irq_pin_in;
    assign pin_raw[PIN_A_RDY] = chan_a_ready_pin_in;
    assign pin_raw[PIN_A_ERR] = chan_a_error_pin_in;
    assign pin_raw[PIN_B_RDY] = chan_b_ready_pin_in;
    assign pin_raw[PIN_B_ERR] = chan_b_error_pin_in;

    spr_sync2 u_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .async_in (pin_raw),
        .sync_out (pin_level)
    );

    // outputs
    assign prdata               = prdata_ff;
    assign pready               = pready_ff;
    assign pslverr              = pslverr_ff;
    assign irq_o                = irq_ff;
    assign irq_pin_out          = pin_out_w[PIN_IRQ];
    assign irq_pin_oe           = pin_oe_w[PIN_IRQ];
    assign chan_a_ready_pin_out = pin_out_w[PIN_A_RDY];
    assign chan_a_ready_pin_oe  = pin_oe_w[PIN_A_RDY];
    assign chan_a_error_pin_out = pin_out_w[PIN_A_ERR];
    assign chan_a_error_pin_oe  = pin_oe_w[PIN_A_ERR];
    assign chan_b_ready_pin_out = pin_out_w[PIN_B_RDY];
    assign chan_b_ready_pin_oe  = pin_oe_w[PIN_B_RDY];
    assign chan_b_error_pin_out = pin_out_w[PIN_B_ERR];
    assign chan_b_error_pin_oe  = pin_oe_w[PIN_B_ERR];

endmodule

//--- spr_status_pin_router_properties.sv
`timescale 1ns/1ns
module spr_status_pin_router_properties
    import spr_pkg::*;
(
    // clock and reset
    input wire logic               clk,
    input wire logic               sys_rst,
    // apb
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire spr_pkg::spr_addr_t paddr,
    input wire spr_pkg::spr_word_t pwdata,
    input wire spr_pkg::spr_word_t prdata,
    input wire logic               pready,
    // events
    input wire logic               chan_a_rx_avail_flag,
    input wire logic               chan_a_rx_fault_flag,
    input wire logic               chan_b_rx_avail_flag,
    input wire logic               chan_b_rx_fault_flag,
    // pins
    input wire logic               irq_o,
    input wire logic               irq_pin_out,
    input wire logic               irq_pin_oe,
    input wire logic               chan_a_ready_pin_out,
    input wire logic               chan_a_ready_pin_oe,
    input wire logic               chan_a_error_pin_out,
    input wire logic               chan_a_error_pin_oe,
    input wire logic               chan_b_ready_pin_out,
    input wire logic               chan_b_ready_pin_oe,
    input wire logic               chan_b_error_pin_out,
    input wire logic               chan_b_error_pin_oe
);
    spr_ev_t  st_ff;
    spr_ev_t  mk_ff;
    spr_ctl_t ct_ff;
    spr_ev_t  ev;
    logic     acc;
    logic     pend;
    assign acc = psel && penable && pready;
    assign ev = {chan_b_rx_fault_flag, chan_b_rx_avail_flag, chan_a_rx_fault_flag,
                 chan_a_rx_avail_flag};
    assign pend = |(st_ff & mk_ff);
    // shadow status: a read clears only what it returned, a new event wins
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_ff <= STATUS_RST;
        end else if (acc && !pwrite && paddr == OFS_STATUS) begin
            st_ff <= (st_ff & ~prdata[NUM_EV-1:0]) | ev;
        end else begin
            st_ff <= st_ff | ev;
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mk_ff <= MASK_RST;
            ct_ff <= CTRL_RST;
        end else if (acc && pwrite && paddr == OFS_MASK) begin
            mk_ff <= pwdata[NUM_EV-1:0];
        end else if (acc && pwrite && paddr == OFS_CTRL) begin
            ct_ff <= pwdata[CTL_W-1:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_setup;
        psel && !penable;
    endsequence
    a_apb_answer: assert property (s_setup |=> pready && psel && penable)
        else $error("no ready in access cycle");
    a_irq_level: assert property (irq_o == $past(pend))
        else $error("irq level wrong");
    a_irq_pin_drive: assert property (irq_pin_oe == irq_o)
        else $error("irq pin differs from irq level");
    a_a_rdy_irq: assert property ($past(ct_ff[0]) |-> chan_a_ready_pin_oe == $past(st_ff[0]))
        else $error("a ready pin wrong in irq mode");
    a_a_rdy_ind: assert property (!$past(ct_ff[0]) |-> chan_a_ready_pin_oe == $past(ct_ff[4]))
        else $error("a ready pin wrong in indicator mode");
    a_b_rdy_irq: assert property ($past(ct_ff[2]) |-> chan_b_ready_pin_oe == $past(st_ff[2]))
        else $error("b ready pin wrong in irq mode");
    a_b_rdy_ind: assert property (!$past(ct_ff[2]) |-> chan_b_ready_pin_oe == $past(ct_ff[6]))
        else $error("b ready pin wrong in indicator mode");
    a_a_err_irq: assert property ($past(ct_ff[1]) |-> chan_a_error_pin_oe == $past(st_ff[1]))
        else $error("a error pin wrong in irq mode");
    a_a_err_ind: assert property (!$past(ct_ff[1]) |-> chan_a_error_pin_oe == $past(ct_ff[5]))
        else $error("a error pin wrong in indicator mode");
    a_b_err_irq: assert property ($past(ct_ff[3]) |-> chan_b_error_pin_oe == $past(st_ff[3]))
        else $error("b error pin wrong in irq mode");
    a_b_err_ind: assert property (!$past(ct_ff[3]) |-> chan_b_error_pin_oe == $past(ct_ff[7]))
        else $error("b error pin wrong in indicator mode");
    a_pins_pull_low: assert property (!(irq_pin_out || chan_a_ready_pin_out ||
        chan_a_error_pin_out || chan_b_ready_pin_out || chan_b_error_pin_out))
        else $error("pin driven high");
endmodule

bind spr_status_pin_router spr_status_pin_router_properties u_props (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .chan_a_rx_avail_flag(chan_a_rx_avail_flag), .chan_a_rx_fault_flag(chan_a_rx_fault_flag),
    .chan_b_rx_avail_flag(chan_b_rx_avail_flag), .chan_b_rx_fault_flag(chan_b_rx_fault_flag),
    .irq_o(irq_o), .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe),
    .chan_a_ready_pin_out(chan_a_ready_pin_out), .chan_a_ready_pin_oe(chan_a_ready_pin_oe),
    .chan_a_error_pin_out(chan_a_error_pin_out), .chan_a_error_pin_oe(chan_a_error_pin_oe),
    .chan_b_ready_pin_out(chan_b_ready_pin_out), .chan_b_ready_pin_oe(chan_b_ready_pin_oe),
    .chan_b_error_pin_out(chan_b_error_pin_out), .chan_b_error_pin_oe(chan_b_error_pin_oe)
);

//--- spr_host_model.sv
`timescale 1ns/1ns
module spr_host_model
    import spr_pkg::*;
(
    // open-drain enables from the device
    input  wire spr_pkg::spr_pins_t pin_oe,
    // wire levels seen by the host
    output spr_pkg::spr_pins_t      pin_lvl
);
    // pull-ups: a released pin reads high, never the last driven level
    assign pin_lvl = ~pin_oe;
endmodule

//--- tb_spr_status_pin_router.sv
`timescale 1ns/1ns
module tb_spr_status_pin_router;
    import spr_pkg::*;
    logic      clk;
    logic      sys_rst;
    logic      psel;
    logic      penable;
    logic      pwrite;
    spr_addr_t paddr;
    spr_word_t pwdata;
    spr_word_t prdata;
    logic      pready;
    logic      pslverr;
    logic      irq_o;
    spr_ev_t   ev;
    wire spr_pins_t oe;
    wire spr_pins_t po;
    wire spr_pins_t lvl;
    int        miscompares;
    int        num_checks;
    spr_word_t rd;
    logic      er;

    spr_status_pin_router dut (
        .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .chan_a_rx_avail_flag(ev[0]), .chan_a_rx_fault_flag(ev[1]),
        .chan_b_rx_avail_flag(ev[2]), .chan_b_rx_fault_flag(ev[3]), .irq_o(irq_o),
        .irq_pin_in(lvl[0]), .irq_pin_out(po[0]), .irq_pin_oe(oe[0]),
        .chan_a_ready_pin_in(lvl[1]), .chan_a_ready_pin_out(po[1]), .chan_a_ready_pin_oe(oe[1]),
        .chan_a_error_pin_in(lvl[2]), .chan_a_error_pin_out(po[2]), .chan_a_error_pin_oe(oe[2]),
        .chan_b_ready_pin_in(lvl[3]), .chan_b_ready_pin_out(po[3]), .chan_b_ready_pin_oe(oe[3]),
        .chan_b_error_pin_in(lvl[4]), .chan_b_error_pin_out(po[4]), .chan_b_error_pin_oe(oe[4])
    );
    spr_host_model host (.pin_oe(oe), .pin_lvl(lvl));

    task end_sim;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task chk(input spr_word_t seen, input spr_word_t exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task apb(input spr_addr_t a, input logic w, input spr_word_t d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        // wait for ready; only the bound ends a hang
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n == 16) miscompares++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task pulse(input int i);
        @(posedge clk);
        ev <= 4'h1 << i;
        @(posedge clk);
        ev <= 4'h0;
    endtask
    // wire levels and their synchronised readback
    task pins(input spr_pins_t exp);
        chk(32'(lvl), 32'(exp));
        apb(OFS_PINS, 1'b0, WORD_ZERO);
        chk(rd, 32'(exp));
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #200000;
        miscompares++;
        end_sim;
    end
    initial begin
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        ev = '0;
        miscompares = 0;
        num_checks = 0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        settle;
        pins(5'h1F);
        apb(OFS_CTRL, 1'b0, WORD_ZERO);
        chk(rd, WORD_ZERO);
        apb(OFS_MASK, 1'b0, WORD_ZERO);
        chk(rd, WORD_ZERO);
        apb(8'h14, 1'b0, WORD_ZERO);
        chk(32'(er), 32'h1);
        // one indicator at a time, all four channel pins in indicator mode
        for (int i = 0; i < 4; i++) begin
            apb(OFS_CTRL, 1'b1, 32'h10 << i);
            settle;
            pins(5'h1F & ~(5'h02 << i));
        end
        // back to back write and readback, bits above the field dropped
        apb(OFS_CTRL, 1'b1, 32'h1FF);
        apb(OFS_CTRL, 1'b0, WORD_ZERO);
        chk(rd, 32'hFF);
        apb(OFS_MASK, 1'b1, 32'h5);
        // interrupt mode overrides lit indicators; mask gates only irq_o, the shared pin and the pending read
        for (int i = 0; i < 4; i++) begin
            pulse(i);
            settle;
            chk(32'(irq_o), 32'(i % 2 == 0));
            pins(5'h1F & ~(5'h02 << i) & ~5'(i % 2 == 0));
            apb(OFS_PEND, 1'b0, WORD_ZERO);
            chk(rd, (i % 2 == 0) ? 32'h1 << i : WORD_ZERO);
            apb(OFS_STATUS, 1'b0, WORD_ZERO);
            chk(rd, 32'h1 << i);
            settle;
            chk(32'(irq_o), 32'h0);
            pins(5'h1F);
        end
        end_sim;
    end
endmodule
